// >>> verification/core_exec_model.sv
// Behavioural model of the core execution logic driving operations and reset-cause strobes.
`timescale 1ns/1ps
module core_exec_model
    import status_bank_pkg::*;
(
    input wire logic i_clk, // Core clock.
    output alu_op_e o_op, // Operation code.
    output logic o_exec, // Execute strobe.
    output logic [DATA_W-1:0] o_opa, // First operand.
    output logic [DATA_W-1:0] o_opb, // Second operand.
    output logic [ADDR_W-1:0] o_dest, // Result destination.
    output logic o_sleep, // Sleep executed.
    output logic o_wdclr, // Watchdog clear executed.
    output logic o_tmo // Watchdog time-out.
);
    // Idle levels from time zero.
    initial begin
        o_op = OP_MOVE;
        o_exec = 1'b0;
        o_opa = 8'h00;
        o_opb = 8'h00;
        o_dest = 12'h000;
        o_sleep = 1'b0;
        o_wdclr = 1'b0;
        o_tmo = 1'b0;
    end

    // One operation after an idle gap; operands are scrambled once the strobe drops.
    task automatic run_op(input alu_op_e op, input logic [7:0] a, input logic [7:0] b,
                          input logic [11:0] d, input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_exec <= 1'b1;
        o_op <= op;
        o_opa <= a;
        o_opb <= b;
        o_dest <= d;
        @(posedge i_clk);
        o_exec <= 1'b0;
        o_opa <= ~a;
        o_opb <= ~b;
    endtask : run_op

    // One reset-cause strobe: 0 sleep, 1 watchdog clear, 2 time-out.
    task automatic pulse(input int which);
        @(posedge i_clk);
        o_sleep <= (which == 0);
        o_wdclr <= (which == 1);
        o_tmo <= (which == 2);
        @(posedge i_clk);
        o_sleep <= 1'b0;
        o_wdclr <= 1'b0;
        o_tmo <= 1'b0;
    endtask : pulse
endmodule : core_exec_model

// >>> verification/testbench.sv
// Self-checking bench for the status flags and banked data memory block.
`timescale 1ns/1ps
module testbench;
    import status_bank_pkg::*;
    localparam int NBANK = 3;
    logic clk, rst, warm, lin, wr, rd, irq, ex, slp, wdc, tmo;
    logic [ADDR_W-1:0] addr, dest, a12;
    logic [DATA_W-1:0] wdata, rdata, status, result, got, v, opa, opb;
    alu_op_e op;
    logic [2:0] flg;
    int failures, cmp_count, seed, i, k, b;

    // Core clock, 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    status_bank_map #(.GPR_BANKS(NBANK)) u_dut (
        .I_MCLK(clk), .I_RST(rst), .I_WARM_RST(warm), .I_ADDR(addr), .I_LINEAR(lin),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_EXEC(ex), .I_OP(op), .I_OPA(opa),
        .I_OPB(opb), .I_DEST(dest), .I_SLEEP(slp), .I_WDT_CLEAR(wdc), .I_WDT_TIMEOUT(tmo),
        .O_RDATA(rdata), .O_STATUS(status), .O_RESULT(result), .O_IRQ(irq)
    );

    core_exec_model u_core (
        .i_clk(clk), .o_op(op), .o_exec(ex), .o_opa(opa), .o_opb(opb), .o_dest(dest),
        .o_sleep(slp), .o_wdclr(wdc), .o_tmo(tmo)
    );

    // Compares one value and reports a mismatch.
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Single-cycle bus write, banked or linear.
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, input logic lin_a = 1'b0);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        lin <= lin_a;
        @(posedge clk);
        wr <= 1'b0;
        lin <= 1'b0;
        #1;
    endtask : bus_wr

    // Single-cycle bus read; data is taken in the following cycle.
    task automatic bus_rd(input logic [11:0] a, input logic lin_a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        lin <= lin_a;
        @(posedge clk);
        rd <= 1'b0;
        lin <= 1'b0;
        #1;
        got = rdata;
    endtask : bus_rd

    // Expected flags in [10:8] and result in [7:0] for one operation.
    function automatic logic [10:0] alu_exp(input alu_op_e o, input logic [7:0] a,
                                            input logic [7:0] b, input logic [2:0] f);
        logic [8:0] s;
        logic [4:0] n;
        logic [2:0] nf;
        nf = f;
        n = 5'h00;
        case (o)
            OP_ADD: s = {1'b0, a} + {1'b0, b};
            OP_SUB: s = {1'b0, a} + {1'b0, ~b} + 9'h001;
            OP_AND: s = {1'b0, a & b};
            OP_IOR: s = {1'b0, a | b};
            OP_XOR: s = {1'b0, a ^ b};
            OP_CLR: s = 9'h000;
            OP_RRF: s = {a[0], f[0], a[7:1]};
            OP_RLF: s = {a, f[0]};
            default: s = {1'b0, a};
        endcase
        if (o == OP_ADD) n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        if (o == OP_SUB) n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        if (o == OP_ADD || o == OP_SUB) nf = {s[7:0] == 8'h00, n[4], s[8]};
        if (o >= OP_AND && o <= OP_CLR) nf[2] = (s[7:0] == 8'h00);
        if (o == OP_RRF || o == OP_RLF) nf[0] = s[8];
        return {nf, s[7:0]};
    endfunction : alu_exp

    // Runs one operation through the core model and checks result and flags.
    task automatic do_op(input alu_op_e o, input logic [7:0] a, input logic [7:0] b,
                         input logic [11:0] d);
        logic [10:0] e;
        e = alu_exp(o, a, b, flg);
        u_core.run_op(o, a, b, d, seed & 1);
        #1;
        flg = (o == OP_MOVE && d[6:0] == LOC_STATUS) ? a[2:0] : e[10:8];
        check("result", result, e[7:0]);
        check("flags", {2'b00, status[7:5], status[2:0]}, {5'h00, flg});
    endtask : do_op

    // Watchdog against a hung run.
    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        seed = 58055;
        failures = 0;
        cmp_count = 0;
        rst = 1'b1;
        warm = 1'b0;
        lin = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 12'h000;
        wdata = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("status_por", status, STATUS_POR);
        bus_wr(12'h583, 8'hE7);
        bus_rd(12'h583, 1'b0);
        check("status_wr", got, 8'h1F);
        flg = 3'h7;
        // General RAM banked and linear, with the last byte of each bank first.
        for (i = 0; i < 6; i++) begin
            b = i % NBANK;
            k = (i < NBANK) ? 79 : $unsigned($random(seed)) % 80;
            v = 8'($random(seed));
            a12 = {b[4:0], 7'(32 + k)};
            bus_wr((i < NBANK) ? a12 : 12'(b * 80 + k), v, i >= NBANK);
            bus_rd(a12, 1'b0);
            check("ram_bank", got, v);
            bus_rd(12'(b * 80 + k), 1'b1);
            check("ram_linear", got, v);
        end
        bus_rd(12'h1A0, 1'b0);
        check("ram_absent", got, 8'h00);
        bus_rd(12'h00C, 1'b0);
        check("periph", got, 8'h00);
        bus_wr(12'h07F, 8'hA5);
        bus_rd(12'hFFF, 1'b0);
        check("common", got, 8'hA5);
        // Every operation once, then random ones aimed at RAM or status.
        for (i = 0; i < 60; i++) begin
            a12 = ($random(seed) & 1) ? 12'h003 : 12'h075;
            do_op((i < 9) ? alu_op_e'(i) : alu_op_e'($unsigned($random(seed)) % 9),
                  8'($random(seed)), 8'($random(seed)), a12);
        end
        do_op(OP_ADD, 8'h0F, 8'h01, 12'h070);
        do_op(OP_SUB, 8'h05, 8'h05, 12'h070);
        do_op(OP_SUB, 8'h03, 8'h05, 12'h070);
        bus_rd(12'h4F0, 1'b0);
        check("common_dest", got, 8'hFE);
        do_op(OP_ADD, 8'hFF, 8'h01, 12'h103);
        bus_rd(12'h003, 1'b0);
        check("status_dest", got, 8'h1F);
        // Reset-cause strobes.
        u_core.pulse(0);
        #1;
        check("sleep", {6'h00, status[4:3]}, 8'h02);
        u_core.pulse(2);
        #1;
        check("timeout", {6'h00, status[4:3]}, 8'h00);
        u_core.pulse(1);
        #1;
        check("wdclr", {6'h00, status[4:3]}, 8'h03);
        u_core.pulse(2);
        #1;
        check("timeout2", {6'h00, status[4:3]}, 8'h01);
        // Interrupt raise, mask, clear and warm reset.
        check("irq_masked", {7'h00, irq}, 8'h00);
        bus_rd(12'hF8C, 1'b0);
        check("ev_stat", got, 8'h07);
        bus_wr(12'hF8D, 8'h01);
        @(posedge clk);
        #1;
        check("irq_on", {7'h00, irq}, 8'h01);
        bus_wr(12'hF8C, 8'h01);
        @(posedge clk);
        #1;
        check("irq_clr", {7'h00, irq}, 8'h00);
        u_core.pulse(2);
        @(posedge clk);
        #1;
        check("irq_again", {7'h00, irq}, 8'h01);
        @(posedge clk);
        warm <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        @(posedge clk);
        #1;
        check("irq_warm", {7'h00, irq}, 8'h00);
        check("status_warm", status, {5'h01, flg});
        print_verdict();
    end
endmodule : testbench

// >>> verilog/flag_alu.sv
// Arithmetic, logic and rotate unit that produces the result and the flag updates.
`timescale 1ns/1ps
module flag_alu
    import status_bank_pkg::*;
(
    input alu_op_e i_op, // Operation code.
    input logic [DATA_W-1:0] i_a, // First operand, also the rotate source.
    input logic [DATA_W-1:0] i_b, // Second operand.
    input logic i_cin, // Present carry flag.
    output logic [DATA_W-1:0] o_res, // Result.
    output logic o_z, // New zero flag.
    output logic o_dc, // New nibble carry flag.
    output logic o_c, // New carry flag.
    output logic o_upd_z, // Zero flag is affected.
    output logic o_upd_dc, // Nibble carry flag is affected.
    output logic o_upd_c // Carry flag is affected.
);

    logic [DATA_W-1:0] b_eff;
    logic sub_in;
    logic [DATA_W:0] sum;
    logic [NIB_W:0] nib;

    // Subtraction adds the two's complement, so carries read as not-borrow.
    always_comb begin
        sub_in = (i_op == OP_SUB); // RULE_07
        b_eff = sub_in ? ~i_b : i_b; // RULE_07
        sum = {1'b0, i_a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, sub_in};
        nib = {1'b0, i_a[NIB_W-1:0]} + {1'b0, b_eff[NIB_W-1:0]} + {{NIB_W{1'b0}}, sub_in};
        o_res = i_a;
        o_c = sum[DATA_W]; // RULE_06
        o_dc = nib[NIB_W]; // RULE_05
        o_upd_z = 1'b0;
        o_upd_dc = 1'b0;
        o_upd_c = 1'b0;
        case (i_op)
            OP_ADD, OP_SUB: begin
                o_res = sum[DATA_W-1:0];
                o_upd_z = 1'b1;
                o_upd_dc = 1'b1;
                o_upd_c = 1'b1;
            end
            OP_AND: begin
                o_res = i_a & i_b;
                o_upd_z = 1'b1;
            end
            OP_IOR: begin
                o_res = i_a | i_b;
                o_upd_z = 1'b1;
            end
            OP_XOR: begin
                o_res = i_a ^ i_b;
                o_upd_z = 1'b1;
            end
            OP_CLR: begin
                o_res = '0;
                o_upd_z = 1'b1;
            end
            OP_RRF: begin
                o_res = {i_cin, i_a[DATA_W-1:1]};
                o_c = i_a[0]; // RULE_08
                o_upd_c = 1'b1;
            end
            OP_RLF: begin
                o_res = {i_a[DATA_W-2:0], i_cin};
                o_c = i_a[DATA_W-1]; // RULE_08
                o_upd_c = 1'b1;
            end
            default: begin
                o_res = i_a;
            end
        endcase
        o_z = (o_res == '0); // RULE_04
    end

endmodule : flag_alu

// >>> verilog/ram_store.sv
// Flip-flop storage for general RAM and common RAM, addressed by an index.
`timescale 1ns/1ps
module ram_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int IDX_W = 8
) (
    input wire logic i_clk, // Core clock.
    input wire logic i_rst, // Asynchronous reset, active high.
    input wire logic i_we, // Write enable.
    input wire logic [IDX_W-1:0] i_widx, // Write index.
    input wire logic [WIDTH-1:0] i_wdata, // Write data.
    input wire logic [IDX_W-1:0] i_ridx, // Read index.
    output logic [WIDTH-1:0] o_rdata // Read data, combinational.
);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];

    // Next contents: one byte replaced on a write.
    always_comb begin
        mem_nxt = mem_r;
        if (i_we) begin
            mem_nxt[i_widx] = i_wdata;
        end
    end

    // Storage registers.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_r <= '{default: '0};
        end else begin
            mem_r <= mem_nxt;
        end
    end

    assign o_rdata = mem_r[i_ridx];

endmodule : ram_store

// >>> verilog/status_bank_map.sv
// Core status register, banked data memory decode and reset-cause flags.
// Notes on behaviour
// RULE_01 - Status bits 7 to 5 read zero and ignore writes.
// RULE_02 - Time-out flag set by power-up, watchdog clear, sleep; cleared by time-out.
// RULE_03 - Power-down flag set by power-up or watchdog clear; cleared by sleep.
// RULE_04 - Zero flag follows whether an arithmetic or logic result is zero.
// RULE_05 - Add and subtract set nibble carry from the carry out of bit 3.
// RULE_06 - Add and subtract set carry from the carry out of the top bit.
// RULE_07 - Subtract adds the two's complement; carries then mean no borrow.
// RULE_08 - Rotates through carry load carry with the bit shifted out.
// RULE_09 - Time-out and power-down read-only; zero, nibble carry, carry writable.
// RULE_10 - Local offsets 0Ch to 1Fh of every bank form the peripheral region.
// RULE_11 - Up to 80 bytes of general RAM per bank after the peripheral region.
// RULE_12 - Local offsets 70h to 7Fh reach the same 16 common bytes in all banks.
// RULE_13 - General RAM also reachable linearly, without banking.
// RULE_14 - Unimplemented data locations read as zero.
// RULE_15 - 12-bit address: upper five bits bank, lower seven bits location.
// RULE_16 - Core registers occupy the first 12 local offsets of every bank.
// RULE_17 - Flag-affecting results aimed at status update flags, not data bits.
// RULE_18 - Sleep, watchdog clear and time-out arrive as single-cycle strobes.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module status_bank_map
    import status_bank_pkg::*;
#(
    parameter int GPR_BANKS = GPR_BANKS_DEF
) (
    input wire logic I_MCLK, // Core clock, 250 MHz.
    input wire logic I_RST, // Power-on or brown-out reset, async, active high.
    input wire logic I_WARM_RST, // Any other reset, synchronous pulse.
    input wire logic [ADDR_W-1:0] I_ADDR, // Data address for bus access.
    input wire logic I_LINEAR, // Address is a linear general RAM index.
    input wire logic [DATA_W-1:0] I_WDATA, // Bus write data.
    input wire logic I_WR, // Bus write strobe.
    input wire logic I_RD, // Bus read strobe.
    input wire logic I_EXEC, // Execute strobe for one operation.
    input alu_op_e I_OP, // Operation code.
    input wire logic [DATA_W-1:0] I_OPA, // First operand.
    input wire logic [DATA_W-1:0] I_OPB, // Second operand.
    input wire logic [ADDR_W-1:0] I_DEST, // Banked destination of the result.
    input wire logic I_SLEEP, // Sleep instruction executed.
    input wire logic I_WDT_CLEAR, // Watchdog clear instruction executed.
    input wire logic I_WDT_TIMEOUT, // Watchdog timer time-out.
    output logic [DATA_W-1:0] O_RDATA, // Read data, cycle after the read.
    output logic [DATA_W-1:0] O_STATUS, // Status register contents.
    output logic [DATA_W-1:0] O_RESULT, // Last operation result.
    output logic O_IRQ // Unmasked event pending.
);

    localparam int RAM_DEPTH = GPR_BANKS * GPR_BYTES + COMMON_BYTES;
    localparam int IDX_W = $clog2(RAM_DEPTH);
    localparam int LIN_BYTES = GPR_BANKS * GPR_BYTES;

    // Maps an address to a RAM index; the top bit flags a hit.
    function automatic logic [IDX_W:0] ram_map(input logic [ADDR_W-1:0] a, input logic lin);
        logic [BANK_W-1:0] bank;
        logic [LOC_W-1:0] loc;
        bank = a[ADDR_W-1 -: BANK_W]; // RULE_15
        loc = a[LOC_W-1:0]; // RULE_15
        ram_map = '0;
        if (lin) begin
            if (int'(a) < LIN_BYTES) begin
                ram_map = {1'b1, IDX_W'(a)}; // RULE_13
            end
        end else if (loc >= LOC_COMMON_FIRST) begin
            ram_map = {1'b1, IDX_W'(LIN_BYTES + int'(loc - LOC_COMMON_FIRST))}; // RULE_12
        end else if (loc >= LOC_GPR_FIRST && int'(bank) < GPR_BANKS) begin
            ram_map = {1'b1, IDX_W'(int'(bank) * GPR_BYTES + int'(loc - LOC_GPR_FIRST))}; // RULE_11
        end
    endfunction : ram_map

    // True when a banked address hits a local offset, in any bank or one bank only.
    function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input logic lin,
                                     input logic [LOC_W-1:0] loc, input logic any_bank);
        reg_sel = !lin && a[LOC_W-1:0] == loc &&
                  (any_bank || a[ADDR_W-1 -: BANK_W] == BANK_EVENTS);
    endfunction : reg_sel

    logic [DATA_W-1:0] alu_res;
    logic alu_z;
    logic alu_dc;
    logic alu_c;
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic wr_en;
    logic wr_lin;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [IDX_W:0] wr_map;
    logic [IDX_W:0] rd_map;
    logic [DATA_W-1:0] ram_q;
    logic st_wr;
    logic flag_block;
    logic rd_hit;
    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] status_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] result_r;
    logic [DATA_W-1:0] result_nxt;
    logic [EV_W-1:0] ev_stat_r;
    logic [EV_W-1:0] ev_stat_nxt;
    logic [EV_W-1:0] ev_mask_r;
    logic [EV_W-1:0] ev_mask_nxt;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic irq_r;
    logic irq_nxt;

    flag_alu u_alu (
        .i_op(I_OP),
        .i_a(I_OPA),
        .i_b(I_OPB),
        .i_cin(status_r[BIT_C]),
        .o_res(alu_res),
        .o_z(alu_z),
        .o_dc(alu_dc),
        .o_c(alu_c),
        .o_upd_z(upd_z),
        .o_upd_dc(upd_dc),
        .o_upd_c(upd_c)
    );

    // One write path: an executed result takes it over a bus write.
    always_comb begin
        wr_en = I_WR | I_EXEC;
        wr_lin = I_EXEC ? 1'b0 : I_LINEAR;
        wr_addr = I_EXEC ? I_DEST : I_ADDR;
        wr_data = I_EXEC ? alu_res : I_WDATA;
        wr_map = ram_map(wr_addr, wr_lin);
        rd_map = ram_map(I_ADDR, I_LINEAR);
        st_wr = wr_en && reg_sel(wr_addr, wr_lin, LOC_STATUS, 1'b1); // RULE_16
        flag_block = I_EXEC && (upd_z || upd_dc || upd_c); // RULE_17
    end

    ram_store #(
        .WIDTH(DATA_W),
        .DEPTH(RAM_DEPTH),
        .IDX_W(IDX_W)
    ) u_ram (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_we(wr_en && wr_map[IDX_W]),
        .i_widx(wr_map[IDX_W-1:0]),
        .i_wdata(wr_data),
        .i_ridx(rd_map[IDX_W-1:0]),
        .o_rdata(ram_q)
    );

    // Status next value: data writes, flag logic, then reset-cause strobes.
    always_comb begin
        status_nxt = status_r;
        if (st_wr && !flag_block) begin
            status_nxt[BIT_Z] = wr_data[BIT_Z]; // RULE_09
            status_nxt[BIT_DC] = wr_data[BIT_DC]; // RULE_09
            status_nxt[BIT_C] = wr_data[BIT_C]; // RULE_09
        end
        if (I_EXEC) begin
            if (upd_z) begin
                status_nxt[BIT_Z] = alu_z; // RULE_04
            end
            if (upd_dc) begin
                status_nxt[BIT_DC] = alu_dc; // RULE_05
            end
            if (upd_c) begin
                status_nxt[BIT_C] = alu_c; // RULE_06
            end
        end
        if (I_WDT_CLEAR) begin
            status_nxt[BIT_TO] = 1'b1; // RULE_02
            status_nxt[BIT_PD] = 1'b1; // RULE_03
        end
        if (I_SLEEP) begin
            status_nxt[BIT_TO] = 1'b1; // RULE_02
            status_nxt[BIT_PD] = 1'b0; // RULE_03
        end
        if (I_WDT_TIMEOUT) begin
            status_nxt[BIT_TO] = 1'b0; // RULE_02
        end
        status_nxt[DATA_W-1:STATUS_IMPL_W] = '0; // RULE_01
        result_nxt = I_EXEC ? alu_res : result_r;
    end

    // Event flags: each strobe is one event, and a set beats a clear.
    always_comb begin
        ev_set = '0;
        ev_set[EV_TIMEOUT] = I_WDT_TIMEOUT; // RULE_18
        ev_set[EV_SLEEP] = I_SLEEP; // RULE_18
        ev_set[EV_WDCLR] = I_WDT_CLEAR; // RULE_18
        ev_clr = '0;
        ev_mask_nxt = ev_mask_r;
        if (wr_en && reg_sel(wr_addr, wr_lin, LOC_EV_STAT, 1'b0)) begin
            ev_clr = wr_data[EV_W-1:0];
        end
        if (wr_en && reg_sel(wr_addr, wr_lin, LOC_EV_MASK, 1'b0)) begin
            ev_mask_nxt = wr_data[EV_W-1:0];
        end
        ev_stat_nxt = (ev_stat_r & ~ev_clr) | ev_set;
        if (I_WARM_RST) begin
            ev_stat_nxt = ev_set;
            ev_mask_nxt = '0;
        end
        irq_nxt = |(ev_stat_nxt & ev_mask_nxt);
    end

    // Read data: valid only in the cycle after the read strobe.
    always_comb begin
        rdata_nxt = '0;
        rd_hit = 1'b0;
        if (rd_map[IDX_W]) begin
            rd_hit = 1'b1;
            rdata_nxt = ram_q;
        end else if (reg_sel(I_ADDR, I_LINEAR, LOC_STATUS, 1'b1)) begin
            rd_hit = 1'b1;
            rdata_nxt = status_r; // RULE_16
        end else if (reg_sel(I_ADDR, I_LINEAR, LOC_EV_STAT, 1'b0)) begin
            rd_hit = 1'b1;
            rdata_nxt = {{(DATA_W - EV_W){1'b0}}, ev_stat_r}; // RULE_10
        end else if (reg_sel(I_ADDR, I_LINEAR, LOC_EV_MASK, 1'b0)) begin
            rd_hit = 1'b1;
            rdata_nxt = {{(DATA_W - EV_W){1'b0}}, ev_mask_r};
        end
        if (!I_RD || I_WARM_RST) begin
            rdata_nxt = '0; // RULE_14
        end
    end

    // Power-on and brown-out reset state; a warm reset keeps the status flags.
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            status_r <= STATUS_POR; // RULE_09
            rdata_r <= '0;
            result_r <= '0;
            ev_stat_r <= '0;
            ev_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            result_r <= result_nxt;
            ev_stat_r <= ev_stat_nxt;
            ev_mask_r <= ev_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_STATUS = status_r;
    assign O_RESULT = result_r;
    assign O_IRQ = irq_r;

    // The unimplemented top bits never show a one.
    property p_upper_zero;
        @(posedge I_MCLK) disable iff (I_RST) O_STATUS[DATA_W-1:STATUS_IMPL_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) // RULE_01
        else $error("Status upper bits not zero.");

    // A time-out clears the time-out flag on the next edge.
    property p_timeout;
        @(posedge I_MCLK) disable iff (I_RST) I_WDT_TIMEOUT |=> !O_STATUS[BIT_TO];
    endproperty
    a_timeout: assert property (p_timeout) // RULE_02
        else $error("Time-out flag not cleared by time-out.");

    // Sleep alone sets time-out and clears power-down.
    property p_sleep;
        @(posedge I_MCLK) disable iff (I_RST)
            I_SLEEP && !I_WDT_TIMEOUT |=> O_STATUS[BIT_TO] && !O_STATUS[BIT_PD];
    endproperty
    a_sleep: assert property (p_sleep) // RULE_03
        else $error("Sleep did not update reset-cause flags.");

    // Watchdog clear without sleep or time-out leaves both reset-cause flags set.
    property p_wdclr;
        @(posedge I_MCLK) disable iff (I_RST)
            I_WDT_CLEAR && !I_SLEEP && !I_WDT_TIMEOUT |=> O_STATUS[BIT_TO] && O_STATUS[BIT_PD];
    endproperty
    a_wdclr: assert property (p_wdclr) // RULE_03
        else $error("Watchdog clear did not set reset-cause flags.");

    // Zero flag agrees with the stored result of a zero-affecting operation.
    property p_zero;
        @(posedge I_MCLK) disable iff (I_RST)
            I_EXEC && I_OP inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR}
            |=> O_STATUS[BIT_Z] == (O_RESULT == '0);
    endproperty
    a_zero: assert property (p_zero) // RULE_04
        else $error("Zero flag disagrees with result.");

    // Addition carries exactly when the sum wrapped, byte and nibble alike.
    property p_add_carry;
        @(posedge I_MCLK) disable iff (I_RST)
            I_EXEC && I_OP == OP_ADD |=> O_STATUS[BIT_C] == (O_RESULT < $past(I_OPA)) &&
            O_STATUS[BIT_DC] == (O_RESULT[NIB_W-1:0] < $past(I_OPA[NIB_W-1:0]));
    endproperty
    a_add_carry: assert property (p_add_carry) // RULE_06
        else $error("Add carry flags wrong.");

    // Subtraction reports carry one when no borrow occurred.
    property p_sub_borrow;
        @(posedge I_MCLK) disable iff (I_RST)
            I_EXEC && I_OP == OP_SUB |=> O_STATUS[BIT_C] == ($past(I_OPA) >= $past(I_OPB)) &&
            O_RESULT == $past(I_OPA) - $past(I_OPB);
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) // RULE_07
        else $error("Subtract borrow wrong.");

    // Rotate right shifts the old carry in and the low bit out to carry.
    property p_rotate;
        @(posedge I_MCLK) disable iff (I_RST)
            I_EXEC && I_OP == OP_RRF |=> O_STATUS[BIT_C] == $past(I_OPA[0]) &&
            O_RESULT[DATA_W-1] == $past(O_STATUS[BIT_C]);
    endproperty
    a_rotate: assert property (p_rotate) // RULE_08
        else $error("Rotate carry wrong.");

    // A cleared result aimed at status sets zero and keeps carry.
    property p_block;
        @(posedge I_MCLK) disable iff (I_RST)
            I_EXEC && I_OP == OP_CLR && reg_sel(I_DEST, 1'b0, LOC_STATUS, 1'b1)
            |=> O_STATUS[BIT_Z] && O_STATUS[BIT_C] == $past(O_STATUS[BIT_C]);
    endproperty
    a_block: assert property (p_block) // RULE_17
        else $error("Status data write not blocked.");

    // Reads that hit nothing and idle cycles return zero.
    property p_unmapped;
        @(posedge I_MCLK) disable iff (I_RST) (!I_RD || !rd_hit) |=> O_RDATA == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) // RULE_14
        else $error("Unmapped read not zero.");

endmodule : status_bank_map

// >>> verilog/status_bank_pkg.sv
// Constants, field layouts and operation codes for the status flags and bank map.
package status_bank_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BANK_W = 5;
    localparam int LOC_W = 7;
    localparam int NIB_W = 4;
    localparam int GPR_BYTES = 80;
    localparam int COMMON_BYTES = 16;
    localparam int GPR_BANKS_DEF = 3;

    // Local offsets inside a bank, and the bank that holds the event registers.
    localparam logic [LOC_W-1:0] LOC_STATUS = 7'h03;
    localparam logic [LOC_W-1:0] LOC_SFR_FIRST = 7'h0C;
    localparam logic [LOC_W-1:0] LOC_GPR_FIRST = 7'h20;
    localparam logic [LOC_W-1:0] LOC_COMMON_FIRST = 7'h70;
    localparam logic [LOC_W-1:0] LOC_EV_STAT = 7'h0C;
    localparam logic [LOC_W-1:0] LOC_EV_MASK = 7'h0D;
    localparam logic [BANK_W-1:0] BANK_EVENTS = 5'h1F;

    // Status register fields.
    localparam int BIT_C = 0;
    localparam int BIT_DC = 1;
    localparam int BIT_Z = 2;
    localparam int BIT_PD = 3;
    localparam int BIT_TO = 4;
    localparam int STATUS_IMPL_W = 5;
    localparam logic [DATA_W-1:0] STATUS_POR = 8'h18;

    // Event status and mask fields.
    localparam int EV_W = 3;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_SLEEP = 1;
    localparam int EV_WDCLR = 2;

    typedef enum logic [3:0] {
        OP_MOVE,
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_CLR,
        OP_RRF,
        OP_RLF
    } alu_op_e;

endpackage : status_bank_pkg
